/* clkdiv_consts.svh */
// register offsets, field positions, reset values and encodings
`ifndef CLKDIV_CONSTS_SVH
`define CLKDIV_CONSTS_SVH

`define ADDR_DIV_CTRL   12'h10a
`define ADDR_DIV_STAT   12'h10b
`define ADDR_DLY_CTRL   12'h110

`define CTRL_AUTO_BIT   7
`define CTRL_NEG_HI     3
`define CTRL_NEG_LO     2
`define CTRL_POS_HI     1
`define CTRL_POS_LO     0
`define STAT_HI         3
`define DMODE_HI        2

`define CTRL_AUTO_RST   1'h0
`define CTRL_SKEW_RST   2'h0
`define STAT_RST        4'h0
`define DMODE_RST       3'h0
`define DMODE_LO        0
`define EFF_RST         5'h00
`define RD_IDLE         8'h00

`define DIV_BY2         3'h1
`define DIV_BY4         3'h3
`define HALVES_BY1      4'h2
`define HALVES_BY2      4'h4
`define HALVES_BY4      4'h8

`define SREF_OFF        2'h0
`define PH_ZERO         4'h0
`define PH_ONE          4'h1
`define SKEW_ZERO       2'h0

`define FINE_MAX_NARROW 8'h10
`define FINE_MAX_WIDE   8'hc0
`define SFINE_MAX       8'h80
`define DELAY_ZERO      8'h00

`endif

/* clkdiv_pkg.sv */
// shared types for the divider alignment block
package clkdiv_pkg;

  typedef logic [3:0] phase_type;

  typedef enum logic [2:0] {
    DLY_NONE        = 3'b000,
    DLY_FINE_NARROW = 3'b010,
    DLY_FINE_LOWJIT = 3'b011,
    DLY_FINE_WIDE   = 3'b100,
    DLY_FINE_SUPER  = 3'b110
  } delay_mode_type;

endpackage

/* sample_delay_decode.sv */
// sample clock delay mode decoder
`timescale 1ns/100ps
`include "clkdiv_consts.svh"

module sample_delay_decode
  import clkdiv_pkg::*;
(
  // mode and raw delay values
  input  wire logic [2:0] mode_i,
  input  wire logic [7:0] fine_i,
  input  wire logic [7:0] superfine_i,
  // applied delays
  output logic      [7:0] fine_o,
  output logic      [7:0] superfine_o,
  output logic            low_jitter_o
);

  logic [7:0] fine_narrow;
  logic [7:0] fine_wide;
  logic [7:0] sfine_lim;

  // out of range steps clamp to the last valid step
  assign fine_narrow = (fine_i > `FINE_MAX_NARROW) ? `FINE_MAX_NARROW
                                                   : fine_i;
  assign fine_wide   = (fine_i > `FINE_MAX_WIDE) ? `FINE_MAX_WIDE : fine_i;
  assign sfine_lim   = (superfine_i > `SFINE_MAX) ? `SFINE_MAX
                                                  : superfine_i;

  always_comb begin
    fine_o       = `DELAY_ZERO;
    superfine_o  = `DELAY_ZERO;
    low_jitter_o = 1'h0;
    case (delay_mode_type'(mode_i))
      DLY_NONE: begin
        fine_o = `DELAY_ZERO;
      end
      DLY_FINE_NARROW: begin
        fine_o = fine_narrow;
      end
      DLY_FINE_LOWJIT: begin
        fine_o       = fine_narrow;
        low_jitter_o = 1'h1;
      end
      DLY_FINE_WIDE: begin
        fine_o = fine_wide;
      end
      DLY_FINE_SUPER: begin
        fine_o      = fine_wide;
        superfine_o = sfine_lim;
      end
      // undefined codes behave as no delay
      default: begin
        fine_o = `DELAY_ZERO;
      end
    endcase
  end

endmodule

/* clkdiv_sysref_align.sv */
// input clock divider alignment to sysref, with skew windows and status
`timescale 1ns/100ps
`include "clkdiv_consts.svh"

module clkdiv_sysref_align
  import clkdiv_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  // register port
  input  wire logic [11:0] addr_i,
  input  wire logic [7:0]  wr_data_i,
  input  wire logic        wr_en_i,
  input  wire logic        rd_en_i,
  output logic      [7:0]  rd_data_o,
  // settings held elsewhere in the map
  input  wire logic [2:0]  div_ratio_i,
  input  wire logic [1:0]  sref_mode_i,
  input  wire logic [3:0]  local_phase_i,
  input  wire logic [7:0]  fine_delay_i,
  input  wire logic [7:0]  superfine_delay_i,
  // sysref, one step per half input clock
  input  wire logic        sysref_i,
  // divider and phase results
  output logic             dev_clk_o,
  output logic      [3:0]  capture_phase_o,
  output logic      [4:0]  eff_phase_o,
  // sample clock delay
  output logic      [2:0]  delay_mode_o,
  output logic      [7:0]  fine_delay_o,
  output logic      [7:0]  superfine_delay_o,
  output logic             low_jitter_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic            auto_en_ff;
  logic            nxt_auto_en;
  logic [1:0]      neg_skew_ff;
  logic [1:0]      nxt_neg_skew;
  logic [1:0]      pos_skew_ff;
  logic [1:0]      nxt_pos_skew;
  logic [2:0]      dmode_ff;
  logic [2:0]      nxt_dmode;
  phase_type       status_ff;
  phase_type       nxt_status;
  phase_type       phase_cnt_ff;
  phase_type       nxt_phase_cnt;
  phase_type       capture_ff;
  phase_type       nxt_capture;
  logic            sref_dly_ff;
  logic            dev_clk_ff;
  logic            nxt_dev_clk;
  logic [4:0]      eff_phase_ff;
  logic [4:0]      nxt_eff_phase;
  logic [7:0]      rd_data_ff;
  logic [7:0]      nxt_rd_data;
  logic [7:0]      fine_ff;
  logic [7:0]      superfine_ff;
  logic            low_jit_ff;

  logic [7:0]      fine_dec;
  logic [7:0]      superfine_dec;
  logic            low_jit_dec;

  phase_type       halves;
  phase_type       ph_plus;
  phase_type       inc_phase;
  phase_type       before_gap;
  logic            sref_edge;
  logic            after_hit;
  logic            before_hit;
  logic            in_window;
  logic            realign;

  ////////////////////////////////////////////////////////////////////////////
  // divider phase and sysref capture

  always_comb begin
    case (div_ratio_i)
      `DIV_BY2: halves = `HALVES_BY2;
      `DIV_BY4: halves = `HALVES_BY4;
      default:  halves = `HALVES_BY1;
    endcase
    ph_plus   = phase_cnt_ff + `PH_ONE;
    // a ratio change mid-count wraps at once rather than run long
    inc_phase = (ph_plus >= halves) ? `PH_ZERO : ph_plus;
    // edges only count while sysref handling is switched on
    sref_edge = sysref_i & ~sref_dly_ff & (sref_mode_i != `SREF_OFF);
    after_hit = phase_cnt_ff <= {2'h0, pos_skew_ff};
    before_gap = halves - phase_cnt_ff;
    before_hit = (phase_cnt_ff != `PH_ZERO)
               && (before_gap <= {2'h0, neg_skew_ff});
    in_window  = after_hit | before_hit;
    // windows and realign gated by auto enable
    realign = sref_edge & auto_en_ff & ~in_window;
    // inside window the count runs on untouched
    nxt_phase_cnt = realign ? `PH_ONE : inc_phase;
    nxt_dev_clk   = nxt_phase_cnt < {1'h0, halves[3:1]};
    // raw phase kept on every accepted edge
    nxt_capture   = sref_edge ? phase_cnt_ff : capture_ff;
    // status holds the phase that was applied
    nxt_status    = realign ? phase_cnt_ff : status_ff;
    nxt_eff_phase = auto_en_ff ? {1'h0, status_ff} + {1'h0, local_phase_i}
                               : {1'h0, local_phase_i};
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      phase_cnt_ff <= `PH_ZERO;
      capture_ff   <= `STAT_RST;
      status_ff    <= `STAT_RST;
      sref_dly_ff  <= 1'h0;
      dev_clk_ff   <= 1'h0;
      eff_phase_ff <= `EFF_RST;
    end else begin
      phase_cnt_ff <= nxt_phase_cnt;
      capture_ff   <= nxt_capture;
      status_ff    <= nxt_status;
      sref_dly_ff  <= sysref_i;
      dev_clk_ff   <= nxt_dev_clk;
      eff_phase_ff <= nxt_eff_phase;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register port

  always_comb begin
    nxt_auto_en  = auto_en_ff;
    nxt_neg_skew = neg_skew_ff;
    nxt_pos_skew = pos_skew_ff;
    nxt_dmode    = dmode_ff;
    nxt_rd_data  = `RD_IDLE;
    if (wr_en_i) begin
      case (addr_i)
        `ADDR_DIV_CTRL: begin
          nxt_auto_en  = wr_data_i[`CTRL_AUTO_BIT];
          nxt_neg_skew = wr_data_i[`CTRL_NEG_HI:`CTRL_NEG_LO];
          nxt_pos_skew = wr_data_i[`CTRL_POS_HI:`CTRL_POS_LO];
        end
        `ADDR_DLY_CTRL: begin
          nxt_dmode = wr_data_i[`DMODE_HI:`DMODE_LO];
        end
        // status is read-only, other addresses ignore writes
        default: begin
          nxt_dmode = dmode_ff;
        end
      endcase
    end
    if (rd_en_i) begin
      case (addr_i)
        `ADDR_DIV_CTRL: begin
          nxt_rd_data = {auto_en_ff, 3'h0, neg_skew_ff, pos_skew_ff};
        end
        `ADDR_DIV_STAT: begin
          nxt_rd_data = {4'h0, status_ff};
        end
        `ADDR_DLY_CTRL: begin
          nxt_rd_data = {5'h00, dmode_ff};
        end
        default: begin
          nxt_rd_data = `RD_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      auto_en_ff  <= `CTRL_AUTO_RST;
      neg_skew_ff <= `CTRL_SKEW_RST;
      pos_skew_ff <= `CTRL_SKEW_RST;
      dmode_ff    <= `DMODE_RST;
      rd_data_ff  <= `RD_IDLE;
    end else begin
      auto_en_ff  <= nxt_auto_en;
      neg_skew_ff <= nxt_neg_skew;
      pos_skew_ff <= nxt_pos_skew;
      dmode_ff    <= nxt_dmode;
      rd_data_ff  <= nxt_rd_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sample clock delay

  sample_delay_decode u_delay_dec (
    .mode_i       (dmode_ff),
    .fine_i       (fine_delay_i),
    .superfine_i  (superfine_delay_i),
    .fine_o       (fine_dec),
    .superfine_o  (superfine_dec),
    .low_jitter_o (low_jit_dec)
  );

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      fine_ff      <= `DELAY_ZERO;
      superfine_ff <= `DELAY_ZERO;
      low_jit_ff   <= 1'h0;
    end else begin
      fine_ff      <= fine_dec;
      superfine_ff <= superfine_dec;
      low_jit_ff   <= low_jit_dec;
    end
  end

  assign rd_data_o         = rd_data_ff;
  assign dev_clk_o         = dev_clk_ff;
  assign capture_phase_o   = capture_ff;
  assign eff_phase_o       = eff_phase_ff;
  assign delay_mode_o      = dmode_ff;
  assign fine_delay_o      = fine_ff;
  assign superfine_delay_o = superfine_ff;
  assign low_jitter_o      = low_jit_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_neg_window_hold: assert property (
    sref_edge && auto_en_ff && phase_cnt_ff != `PH_ZERO
    && (halves - phase_cnt_ff) <= {2'b00, neg_skew_ff}
    |=> phase_cnt_ff == $past(inc_phase) && $stable(status_ff))
    else $error("edge in negative window moved the divider");

  a_pos_window_hold: assert property (
    sref_edge && auto_en_ff && phase_cnt_ff <= {2'b00, pos_skew_ff}
    |=> phase_cnt_ff == $past(inc_phase))
    else $error("edge in positive window moved the divider");

  a_auto_off_free: assert property (
    !auto_en_ff |=> phase_cnt_ff == $past(inc_phase)
                    && $stable(status_ff))
    else $error("divider disturbed with auto adjust off");

  a_window_keeps: assert property (
    sref_edge && in_window ##1 !sref_edge
    |=> phase_cnt_ff == $past(inc_phase, 2) + `PH_ONE
        || phase_cnt_ff == `PH_ZERO || $past(div_ratio_i) != div_ratio_i)
    else $error("in-window capture shifted the count");

  a_status_read: assert property (
    rd_en_i && addr_i == `ADDR_DIV_STAT
    |=> rd_data_o == {4'h0, $past(status_ff)})
    else $error("status read returned wrong value");

  a_zero_win_status: assert property (
    sref_edge && auto_en_ff && neg_skew_ff == `SKEW_ZERO
    && pos_skew_ff == `SKEW_ZERO && phase_cnt_ff != `PH_ZERO
    |=> status_ff == capture_phase_o)
    else $error("status differs from raw captured phase");

  a_mode_none_zero: assert property (
    dmode_ff == DLY_NONE |=> fine_delay_o == `DELAY_ZERO
                             && superfine_delay_o == `DELAY_ZERO)
    else $error("delay applied in no-delay mode");

  a_mode_limits: assert property (
    (dmode_ff == DLY_FINE_NARROW || dmode_ff == DLY_FINE_LOWJIT)
    |=> fine_delay_o <= `FINE_MAX_NARROW
        && superfine_delay_o == `DELAY_ZERO
        && low_jitter_o == ($past(dmode_ff) == DLY_FINE_LOWJIT))
    else $error("narrow fine mode out of range");

  a_eff_offset_sum: assert property (
    auto_en_ff |=> eff_phase_o
                   == {1'b0, $past(status_ff)} + {1'b0, $past(local_phase_i)})
    else $error("effective offset is not capture plus local");

  a_realign_count: assert property (
    realign |=> phase_cnt_ff == `PH_ONE
                && status_ff == $past(phase_cnt_ff)
                && capture_phase_o == status_ff)
    else $error("outside capture did not realign");

  c_realign: cover property (realign ##[1:20] realign);
  c_window_hit: cover property (sref_edge && auto_en_ff && in_window);
  c_super_mode: cover property (dmode_ff == DLY_FINE_SUPER
                                && superfine_dec != `DELAY_ZERO);
  c_status_read: cover property (rd_en_i && addr_i == `ADDR_DIV_STAT
                                 && status_ff != `STAT_RST);

endmodule

/* sysref_src.sv */
// sysref source model: single pulses lasting len_i plus one cycles
`timescale 1ns/100ps

module sysref_src (
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  // pulse request
  input  wire logic       fire_i,
  input  wire logic [3:0] len_i,
  // sysref line
  output logic            sysref_o
);
  logic [4:0] left_ff;
  logic [4:0] nxt_left;

  always_comb begin
    nxt_left = left_ff;
    if (left_ff != 5'h00)
      nxt_left = left_ff - 5'h01;
    else if (fire_i)
      nxt_left = {1'h0, len_i} + 5'h02;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i)
      left_ff <= 5'h00;
    else
      left_ff <= nxt_left;
  end

  // last count is low so the next pulse has a clean rising edge
  assign sysref_o = (left_ff > 5'h01);
endmodule

/* testbench.sv */
// self-checking bench for the divider alignment block
`timescale 1ns/100ps

module testbench;
  import clkdiv_pkg::*;

  logic        clk, rst_n, we, re, fire, sref, devclk, lj;
  logic [11:0] addr;
  logic [7:0]  wdat, rdat, fin, sfin, fino, sfino, ctrl_m;
  logic [2:0]  ratio, dm;
  logic [1:0]  smode, rst_q;
  logic [3:0]  lph, flen, capph, cnt_m, cap_m, st_m, hv, sk;
  logic [4:0]  effph, eff_m;
  logic        sr_q, edge_m, inwin, realign;
  logic [7:0]  fv;
  int          errors, num_checks, cyc;

  clkdiv_sysref_align i_clkdiv_sysref_align (
    .sys_clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wr_data_i(wdat),
    .wr_en_i(we), .rd_en_i(re), .rd_data_o(rdat), .div_ratio_i(ratio),
    .sref_mode_i(smode), .local_phase_i(lph), .fine_delay_i(fin),
    .superfine_delay_i(sfin), .sysref_i(sref), .dev_clk_o(devclk),
    .capture_phase_o(capph), .eff_phase_o(effph), .delay_mode_o(dm),
    .fine_delay_o(fino), .superfine_delay_o(sfino), .low_jitter_o(lj));

  sysref_src i_sysref_src (
    .sys_clk_i(clk), .rst_n_i(rst_n), .fire_i(fire), .len_i(flen),
    .sysref_o(sref));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    we <= 1'h1; addr <= a; wdat <= d;
    @(posedge clk);
    we <= 1'h0;
  endtask

  task automatic rdc(input string nm, input logic [11:0] a,
                     input logic [7:0] e);
    @(posedge clk);
    re <= 1'h1; addr <= a;
    @(posedge clk);
    re <= 1'h0;
    #1 chk(nm, e, rdat);
  endtask

  task automatic do_reset(input logic [2:0] r);
    @(posedge clk);
    rst_n <= 1'h0; ratio <= r; smode <= 2'h0;
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
  endtask

  function automatic logic [7:0] exp_fine(input logic [2:0] md,
                                          input logic [7:0] v);
    case (md)
      3'h2, 3'h3: return (v > 8'h10) ? 8'h10 : v;
      3'h4, 3'h6: return (v > 8'hc0) ? 8'hc0 : v;
      default: return 8'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // reference divider, snooping the register port
  always_comb begin
    hv = (ratio == 3'h1) ? 4'h4 : (ratio == 3'h3) ? 4'h8 : 4'h2;
    edge_m = sref && !sr_q && (smode != 2'h0);
    inwin = (cnt_m <= {2'h0, ctrl_m[1:0]}) ||
            (cnt_m != 4'h0 && hv - cnt_m <= {2'h0, ctrl_m[3:2]});
    realign = edge_m && ctrl_m[7] && !inwin;
  end

  always_ff @(posedge clk) begin
    rst_q <= {rst_q[0], rst_n};
    sr_q <= sref;
    eff_m <= (ctrl_m[7] ? {1'h0, st_m} : 5'h00) + {1'h0, lph};
    if (!rst_n) begin
      cnt_m <= 4'h0; cap_m <= 4'h0; st_m <= 4'h0; ctrl_m <= 8'h00;
    end else begin
      cnt_m <= realign ? 4'h1 : (cnt_m + 4'h1 == hv) ? 4'h0 : cnt_m + 4'h1;
      if (edge_m) cap_m <= cnt_m;
      if (realign) st_m <= cnt_m;
      if (we && addr == 12'h10a) ctrl_m <= wdat & 8'h8f;
    end
  end

  always @(negedge clk) begin
    // ratio and flops jump as reset falls, so skip while it is low
    if (rst_q[1] && rst_n) begin
      chk("dev_clk", {7'h0, cnt_m < (hv >> 1)}, {7'h0, devclk});
      chk("capture", {4'h0, cap_m}, {4'h0, capph});
      chk("eff_phase", {3'h0, eff_m}, {3'h0, effph});
    end
  end

  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 12000) begin
      errors++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'h0; we = 1'h0; re = 1'h0; addr = 12'h000; wdat = 8'h00;
    ratio = 3'h0; smode = 2'h0; lph = 4'h0; fin = 8'h00; sfin = 8'h00;
    fire = 1'h0; flen = 4'h0;
    void'($urandom(65));
    do_reset(3'h3);
    rdc("ctrl_rst", 12'h10a, 8'h00);
    rdc("stat_rst", 12'h10b, 8'h00);
    rdc("dly_rst", 12'h110, 8'h00);
    wr(12'h10a, 8'hf8);
    wr(12'h10b, 8'hff);
    rdc("ctrl_rd", 12'h10a, 8'h88);
    rdc("stat_ro", 12'h10b, 8'h00);
    rdc("unmapped", 12'h10c, 8'h00);
    @(posedge clk);
    #1 chk("rd_idle", 8'h00, rdat);
    for (int k = 0; k < 2; k++) begin
      for (int m = 0; m < 8; m++) begin
        fv = (m < 4) ? 8'(8'h11 + m) : 8'(8'hc0 + m);
        if (k == 1) fv = 8'($urandom);
        fin <= fv;
        sfin <= 8'($urandom) | 8'(k << 7);
        wr(12'h110, 8'(m));
        repeat (3) @(posedge clk);
        #1 chk("mode", {5'h0, 3'(m)}, {5'h0, dm});
        chk("fine", exp_fine(3'(m), fin), fino);
        chk("low_jit", {7'h0, m == 3}, {7'h0, lj});
        if (m == 6)
          chk("sfine", (sfin > 8'h80) ? 8'h80 : sfin, sfino);
        if (m != 6)
          chk("sfine_off", 8'h00, sfino);
        rdc("dly_rd", 12'h110, {5'h0, 3'(m)});
      end
    end
    for (int r = 0; r < 4; r++) begin
      do_reset(3'(r));
      repeat (14) begin
        smode <= 2'h0;
        lph <= 4'($urandom);
        sk = 4'($urandom);
        while ({2'h0, sk[3:2]} + {2'h0, sk[1:0]} >= 4'(r) && sk != 4'h0)
          sk = 4'($urandom);
        wr(12'h10a, {1'($urandom), 3'h0, sk});
        smode <= 2'($urandom);
        repeat ($urandom_range(0, 9)) @(posedge clk);
        fire <= 1'h1;
        flen <= 4'($urandom);
        @(posedge clk);
        fire <= 1'h0;
        repeat (24) @(posedge clk);
        rdc("status", 12'h10b, {4'h0, st_m});
      end
    end
    stop_test();
  end
endmodule
